/* shared/crtg_pkg.sv */
// Package: register map, field layouts and timing constants of the CRT raster timing generator
//
// Notes on behaviour
// - Each line lasts horizontal total plus one
// - Frame lasts coarse+1 rows plus fine+1 lines
// - Visible region lasts visible rows times row time; here rows from 24 on and columns from 80 on stay blanked even inside it
// - Vertical sync starts after position plus one rows
// - Blanking interval lasts at least eight microseconds; BLANK_MIN_CH is not used to enforce it
// - Text screen is 24 rows by 80 columns
// - Per-character colours from eight-colour palette, flashing allowed; here one attribute register colours every character
// - Row lasts line period times lines-per-row plus one
// - Character clock 3.2727 or 1.6364 MHz by jumper
`default_nettype none
package crtg_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_HORIZONTAL_TOTAL      = 8'h00;
	localparam logic [7:0] ADDR_VERTICAL_TOTAL_COARSE = 8'h04;
	localparam logic [7:0] ADDR_VERTICAL_TOTAL_FINE   = 8'h08;
	localparam logic [7:0] ADDR_VERTICAL_VISIBLE_ROWS = 8'h0C;
	localparam logic [7:0] ADDR_VSYNC_POSITION        = 8'h10;
	localparam logic [7:0] ADDR_RASTER_LINES_PER_ROW  = 8'h14;
	localparam logic [7:0] ADDR_CONTROL               = 8'h18;
	localparam logic [7:0] ADDR_STATUS                = 8'h1C;
	localparam logic [7:0] ADDR_ATTRIBUTE             = 8'h20;
	// Field widths
	localparam int HT_W  = 8;
	localparam int VTC_W = 7;
	localparam int VTF_W = 5;
	localparam int VVR_W = 7;
	localparam int VSP_W = 7;
	localparam int RLR_W = 7;
	// Reset values: low-resolution 50 Hz standard set
	localparam logic [HT_W-1:0]  RST_HORIZONTAL_TOTAL      = 8'h69;
	localparam logic [VTC_W-1:0] RST_VERTICAL_TOTAL_COARSE = 7'h21;
	localparam logic [VTF_W-1:0] RST_VERTICAL_TOTAL_FINE   = 5'h03;
	localparam logic [VVR_W-1:0] RST_VERTICAL_VISIBLE_ROWS = 7'h1A;
	localparam logic [VSP_W-1:0] RST_VSYNC_POSITION        = 7'h1D;
	localparam logic [RLR_W-1:0] RST_RASTER_LINES_PER_ROW  = 7'h08;
	// Control fields
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_HIRES_BIT  = 1;
	localparam int CTL_VSYNC_LEN_LSB = 4;
	localparam int CTL_HSYNC_POS_LSB = 8;
	localparam logic [3:0] RST_VSYNC_LEN = 4'h2;
	localparam logic [7:0] RST_HSYNC_POS = 8'h58;
	localparam logic [3:0] HSYNC_LEN     = 4'h7;
	// Screen format
	localparam int SCREEN_ROWS = 24;
	localparam int SCREEN_COLS = 80;
	// Character rates and system clock
	localparam int CLK_HZ        = 50_000_000;
	localparam int CHAR_HI_HZ    = 3_272_700;
	localparam int CHAR_LO_HZ    = 1_636_400;
	localparam int CHAR_HI_DIV   = (CLK_HZ + CHAR_HI_HZ / 2) / CHAR_HI_HZ;
	localparam int CHAR_LO_DIV   = (CLK_HZ + CHAR_LO_HZ / 2) / CHAR_LO_HZ;
	// Least blanking time in ns and in character times at high resolution
	localparam int BLANK_MIN_NS  = 8_000;
	localparam int CHAR_HI_NS    = CHAR_HI_DIV * 20;
	localparam int BLANK_MIN_CH  = (BLANK_MIN_NS + CHAR_HI_NS - 1) / CHAR_HI_NS;
	// AXI4-Lite response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Video word out of the buffer
	typedef struct packed {
		logic [6:0] col;
		logic [4:0] row;
		logic [2:0] fg;
		logic [2:0] bg;
		logic       flash_on;
		logic       visible;
	} crtg_pix_s;
endpackage : crtg_pkg
`default_nettype wire

/* src/crtg_top.sv */
// CRT raster timing generator with AXI4-Lite registers and buffered video position stream
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module crtg_top #(
	parameter int HI_DIV = crtg_pkg::CHAR_HI_DIV,
	parameter int LO_DIV = crtg_pkg::CHAR_LO_DIV
) (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// Jumper selecting high resolution
	input  wire logic                hires_jumper,
	// AXI4-Lite write
	input  wire logic [7:0]          s_awaddr,
	input  wire logic                s_awvalid,
	output logic                     s_awready,
	input  wire logic [31:0]         s_wdata,
	input  wire logic [3:0]          s_wstrb,
	input  wire logic                s_wvalid,
	output logic                     s_wready,
	output logic [1:0]               s_bresp,
	output logic                     s_bvalid,
	input  wire logic                s_bready,
	// AXI4-Lite read
	input  wire logic [7:0]          s_araddr,
	input  wire logic                s_arvalid,
	output logic                     s_arready,
	output logic [31:0]              s_rdata,
	output logic [1:0]               s_rresp,
	output logic                     s_rvalid,
	input  wire logic                s_rready,
	// Monitor side
	output logic                     hsync,
	output logic                     vsync,
	output logic                     blank,
	output logic                     char_tick,
	// Video position stream
	output crtg_pkg::crtg_pix_s      pix_data,
	output logic                     pix_valid,
	input  wire logic                pix_ready
);
	if (HI_DIV < 2 || LO_DIV < 2 || HI_DIV > 128 || LO_DIV > 128) begin : g_bad_div
		$error("divider out of range");
	end

	// Register file
	logic [7:0]  ht_q, ht_d;
	logic [6:0]  vtc_q, vtc_d, vvr_q, vvr_d, vsp_q, vsp_d, rlr_q, rlr_d;
	logic [4:0]  vtf_q, vtf_d;
	logic [15:0] ctl_q, ctl_d;
	logic [6:0]  attr_q, attr_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        aw_ok, w_ok, wr_go, rd_go;
	// Timing counters
	logic [6:0]  div_q, div_d;
	logic [7:0]  hcnt_q, hcnt_d;
	logic [6:0]  rast_q, rast_d, row_q, row_d;
	logic        fine_q, fine_d, stall;
	logic [4:0]  fcnt_q, fcnt_d;
	logic [3:0]  vsl_q, vsl_d;
	logic        hs_q, hs_d, vs_q, vs_d, bl_q, bl_d, vis_q, vis_d;
	logic        frame_wrap, line_wrap;
	// Buffer
	crtg_pkg::crtg_pix_s buf_q [2];
	crtg_pkg::crtg_pix_s buf_d [2];
	logic [1:0]  cnt_q, cnt_d;
	crtg_pkg::crtg_pix_s in_word;
	logic        in_valid, in_ready;

	assign aw_ok = s_awvalid && !bvalid_q;
	assign w_ok  = s_wvalid && !bvalid_q;
	assign wr_go = aw_ok && w_ok;
	assign rd_go = s_arvalid && !rvalid_q;
	assign s_awready = wr_go;
	assign s_wready  = wr_go;
	assign s_arready = rd_go;

	always_comb begin
		ht_d = ht_q; vtc_d = vtc_q; vtf_d = vtf_q; vvr_d = vvr_q;
		vsp_d = vsp_q; rlr_d = rlr_q; ctl_d = ctl_q; attr_d = attr_q;
		bvalid_d = bvalid_q && !s_bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !s_rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (wr_go) begin
			bvalid_d = 1'b1;
			bresp_d = crtg_pkg::RESP_OKAY;
			case (s_awaddr)
				crtg_pkg::ADDR_HORIZONTAL_TOTAL: if (s_wstrb[0]) ht_d = s_wdata[7:0];
				crtg_pkg::ADDR_VERTICAL_TOTAL_COARSE: if (s_wstrb[0]) vtc_d = s_wdata[6:0];
				crtg_pkg::ADDR_VERTICAL_TOTAL_FINE: if (s_wstrb[0]) vtf_d = s_wdata[4:0];
				crtg_pkg::ADDR_VERTICAL_VISIBLE_ROWS: if (s_wstrb[0]) vvr_d = s_wdata[6:0];
				crtg_pkg::ADDR_VSYNC_POSITION: if (s_wstrb[0]) vsp_d = s_wdata[6:0];
				crtg_pkg::ADDR_RASTER_LINES_PER_ROW: if (s_wstrb[0]) rlr_d = s_wdata[6:0];
				crtg_pkg::ADDR_CONTROL: begin
					if (s_wstrb[0]) ctl_d[7:0] = s_wdata[7:0];
					if (s_wstrb[1]) ctl_d[15:8] = s_wdata[15:8];
				end
				crtg_pkg::ADDR_ATTRIBUTE: if (s_wstrb[0]) attr_d = s_wdata[6:0];
				crtg_pkg::ADDR_STATUS: bresp_d = crtg_pkg::RESP_OKAY;
				default: bresp_d = crtg_pkg::RESP_SLVERR;
			endcase
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d = crtg_pkg::RESP_OKAY;
			case (s_araddr)
				crtg_pkg::ADDR_HORIZONTAL_TOTAL: rdata_d = {24'h00_0000, ht_q};
				crtg_pkg::ADDR_VERTICAL_TOTAL_COARSE: rdata_d = {25'h000_0000, vtc_q};
				crtg_pkg::ADDR_VERTICAL_TOTAL_FINE: rdata_d = {27'h000_0000, vtf_q};
				crtg_pkg::ADDR_VERTICAL_VISIBLE_ROWS: rdata_d = {25'h000_0000, vvr_q};
				crtg_pkg::ADDR_VSYNC_POSITION: rdata_d = {25'h000_0000, vsp_q};
				crtg_pkg::ADDR_RASTER_LINES_PER_ROW: rdata_d = {25'h000_0000, rlr_q};
				crtg_pkg::ADDR_CONTROL: rdata_d = {16'h0000, ctl_q};
				crtg_pkg::ADDR_STATUS: rdata_d = {8'h00, row_q, 1'b0, hcnt_q, vs_q, hs_q, vis_q, bl_q, fcnt_q[3:0]};
				crtg_pkg::ADDR_ATTRIBUTE: rdata_d = {25'h000_0000, attr_q};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = crtg_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Timing chain, held while the buffer is full
	assign stall = !in_ready;
	always_comb begin
		div_d = div_q; hcnt_d = hcnt_q; rast_d = rast_q; row_d = row_q;
		fine_d = fine_q; fcnt_d = fcnt_q; vsl_d = vsl_q;
		hs_d = hs_q; vs_d = vs_q; bl_d = bl_q; vis_d = vis_q;
		line_wrap = 1'b0;
		frame_wrap = 1'b0;
		char_tick = 1'b0;
		if (ctl_q[crtg_pkg::CTL_ENABLE_BIT] && !stall) begin
			if (div_q == 7'((hires_jumper ? HI_DIV : LO_DIV) - 1)) begin
				div_d = 7'h00;
				char_tick = 1'b1;
			end else begin
				div_d = div_q + 7'h01;
			end
		end
		if (char_tick) begin
			// Line of ht plus one characters
			line_wrap = (hcnt_q == ht_q);
			hcnt_d = line_wrap ? 8'h00 : hcnt_q + 8'h01;
			hs_d = (hcnt_d >= ctl_q[15:8]) && (hcnt_d < ctl_q[15:8] + 8'(crtg_pkg::HSYNC_LEN));
			if (line_wrap) begin
				if (fine_q) begin
					frame_wrap = (rast_q == 7'(vtf_q));
					rast_d = frame_wrap ? 7'h00 : rast_q + 7'h01;
					if (frame_wrap) begin
						fine_d = 1'b0;
						row_d = 7'h00;
						fcnt_d = fcnt_q + 5'h01;
					end
				// Row of rlr plus one lines
				end else if (rast_q == rlr_q) begin
					rast_d = 7'h00;
					if (row_q == vtc_q) fine_d = 1'b1;
					else row_d = row_q + 7'h01;
				end else begin
					rast_d = rast_q + 7'h01;
				end
				// Vertical sync after position plus one rows
				if (!fine_d && row_d == vsp_q + 7'h01 && rast_d == 7'h00) begin
					vs_d = 1'b1;
					vsl_d = ctl_q[7:4];
				end else if (vs_q) begin
					if (vsl_q == 4'h0) vs_d = 1'b0;
					else vsl_d = vsl_q - 4'h1;
				end
			end
			// Eighty columns by 24 rows at most
			vis_d = !fine_d && row_d < vvr_q && row_d < 7'(crtg_pkg::SCREEN_ROWS)
				&& hcnt_d < 8'(crtg_pkg::SCREEN_COLS);
			bl_d = !vis_d;
		end
	end

	// Pixel word: colours, flash phase from frame counter
	always_comb begin
		in_word.col = hcnt_q[6:0];
		in_word.row = row_q[4:0];
		in_word.fg = attr_q[2:0];
		in_word.bg = attr_q[5:3];
		in_word.flash_on = !(attr_q[6] && fcnt_q[4]);
		in_word.visible = vis_q;
	end
	assign in_valid = char_tick;

	// Two-entry buffer
	assign in_ready = (cnt_q != 2'd2);
	assign pix_valid = (cnt_q != 2'd0);
	assign pix_data = buf_q[0];
	always_comb begin
		buf_d[0] = buf_q[0];
		buf_d[1] = buf_q[1];
		cnt_d = cnt_q;
		if (pix_valid && pix_ready) begin
			buf_d[0] = buf_q[1];
			cnt_d = cnt_q - 2'd1;
		end
		if (in_valid && in_ready) begin
			buf_d[cnt_d[0]] = in_word;
			cnt_d = cnt_d + 2'd1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ht_q <= crtg_pkg::RST_HORIZONTAL_TOTAL;
			vtc_q <= crtg_pkg::RST_VERTICAL_TOTAL_COARSE;
			vtf_q <= crtg_pkg::RST_VERTICAL_TOTAL_FINE;
			vvr_q <= crtg_pkg::RST_VERTICAL_VISIBLE_ROWS;
			vsp_q <= crtg_pkg::RST_VSYNC_POSITION;
			rlr_q <= crtg_pkg::RST_RASTER_LINES_PER_ROW;
			ctl_q <= {crtg_pkg::RST_HSYNC_POS, crtg_pkg::RST_VSYNC_LEN, 4'h1};
			attr_q <= 7'h07;
			bvalid_q <= 1'b0; bresp_q <= 2'b00;
			rvalid_q <= 1'b0; rresp_q <= 2'b00; rdata_q <= 32'h0000_0000;
			div_q <= 7'h00; hcnt_q <= 8'h00; rast_q <= 7'h00; row_q <= 7'h00;
			fine_q <= 1'b0; fcnt_q <= 5'h00; vsl_q <= 4'h0;
			hs_q <= 1'b0; vs_q <= 1'b0; bl_q <= 1'b1; vis_q <= 1'b0;
			cnt_q <= 2'd0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			ht_q <= ht_d; vtc_q <= vtc_d; vtf_q <= vtf_d; vvr_q <= vvr_d;
			vsp_q <= vsp_d; rlr_q <= rlr_d; ctl_q <= ctl_d; attr_q <= attr_d;
			bvalid_q <= bvalid_d; bresp_q <= bresp_d;
			rvalid_q <= rvalid_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
			div_q <= div_d; hcnt_q <= hcnt_d; rast_q <= rast_d; row_q <= row_d;
			fine_q <= fine_d; fcnt_q <= fcnt_d; vsl_q <= vsl_d;
			hs_q <= hs_d; vs_q <= vs_d; bl_q <= bl_d; vis_q <= vis_d;
			cnt_q <= cnt_d;
			buf_q[0] <= buf_d[0];
			buf_q[1] <= buf_d[1];
		end
	end

	assign s_bvalid = bvalid_q;
	assign s_bresp = bresp_q;
	assign s_rvalid = rvalid_q;
	assign s_rresp = rresp_q;
	assign s_rdata = rdata_q;
	assign hsync = hs_q;
	assign vsync = vs_q;
	assign blank = bl_q;

	chk_line_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		char_tick && hcnt_q == ht_q |=> hcnt_q == 8'h00) else $error("line did not wrap");
	chk_hcnt_step: assert property (@(posedge aclk) disable iff (!aresetn)
		char_tick && hcnt_q != ht_q |=> hcnt_q == $past(hcnt_q) + 8'h01) else $error("bad column step");
	chk_frame_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		frame_wrap |=> row_q == 7'h00 && rast_q == 7'h00 && !fine_q) else $error("frame wrap wrong");
	chk_row_len: assert property (@(posedge aclk) disable iff (!aresetn)
		line_wrap && !fine_q && rast_q == rlr_q |=> rast_q == 7'h00) else $error("row did not end");
	// Visible rows judged against the limit in force at the tick
	chk_vis_rows: assert property (@(posedge aclk) disable iff (!aresetn)
		vis_q && $past(char_tick) |-> row_q < $past(vvr_q) && !fine_q) else $error("visible outside rows");
	chk_screen_fmt: assert property (@(posedge aclk) disable iff (!aresetn)
		vis_q |-> hcnt_q < 8'(crtg_pkg::SCREEN_COLS) && row_q < 7'(crtg_pkg::SCREEN_ROWS))
		else $error("visible outside screen");
	chk_blank_vis: assert property (@(posedge aclk) disable iff (!aresetn)
		blank != vis_q && (!fine_q || blank)) else $error("blank mismatch");
	// Position taken from the cycle that decided the rise
	chk_vsync_pos: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(vs_q) |-> row_q == $past(vsp_q) + 7'h01 && rast_q == 7'h00) else $error("vsync misplaced");
	chk_buf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		pix_valid && !pix_ready |=> pix_valid && $stable(pix_data)) else $error("buffer word lost");
endmodule : crtg_top
`default_nettype wire

/* verif/crtg_monitor_model.sv */
// Monitor model: takes the position stream and measures raster timing
`timescale 1ns/1ps
`default_nettype none
module crtg_monitor_model (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// Sync and stream
	input  wire logic                hsync,
	input  wire logic                vsync,
	input  wire logic                blank,
	input  wire logic                char_tick,
	input  wire crtg_pkg::crtg_pix_s pix_data,
	input  wire logic                pix_valid,
	output logic                     pix_ready,
	// Stall control and measurements
	input  wire logic                hold,
	input  wire logic                jitter,
	output int                       line_chars,
	output int                       line_clks,
	output int                       frame_lines,
	output int                       vis_chars,
	output int                       vs_chars,
	output int                       n_tick,
	output int                       n_xfer,
	output crtg_pkg::crtg_pix_s      last_vis
);
	logic       hs_q, vs_q, bl_q;
	logic [7:0] lfsr_q;
	int         c_ch, c_clk, c_ln, c_vis, c_vs;
	// Random stalls from the far side
	assign pix_ready = !hold && (!jitter || lfsr_q[0]);
	always_ff @(posedge aclk) begin
		hs_q <= hsync;
		vs_q <= vsync;
		bl_q <= blank;
		lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		if (!aresetn) begin
			lfsr_q <= 8'h5a;
			n_tick <= 0;
			n_xfer <= 0;
		end else begin
			n_tick <= n_tick + int'(char_tick);
			if (pix_valid && pix_ready) begin
				n_xfer <= n_xfer + 1;
				if (pix_data.visible)
					last_vis <= pix_data;
			end
			c_ch <= c_ch + int'(char_tick);
			c_clk <= c_clk + 1;
			c_ln <= c_ln + int'(hsync && !hs_q);
			c_vis <= c_vis + int'(char_tick && !blank);
			c_vs <= c_vs + int'(char_tick);
			if (bl_q && !blank)
				c_vs <= 0;
			if (hsync && !hs_q) begin
				line_chars <= c_ch;
				line_clks <= c_clk;
				c_ch <= 0;
				c_clk <= 1;
			end
			if (vsync && !vs_q) begin
				frame_lines <= c_ln;
				vis_chars <= c_vis;
				vs_chars <= c_vs;
				c_ln <= int'(hsync && !hs_q);
				c_vis <= 0;
			end
		end
	end
endmodule : crtg_monitor_model
`default_nettype wire

/* verif/tb_crtg_top.sv */
// Self-checking bench: register access, raster timing and position stream
`timescale 1ns/1ps
`default_nettype none
module tb_crtg_top;
	localparam int HI = 2;
	localparam int LO = 3;
	localparam logic [31:0] RV [9] = '{32'h0000_0069, 32'h0000_0021, 32'h0000_0003, 32'h0000_001A,
		32'h0000_001D, 32'h0000_0008, 32'h0000_5821, 32'h0000_0000, 32'h0000_0007};
	localparam logic [31:0] MK [9] = '{32'h0000_00FF, 32'h0000_007F, 32'h0000_001F, 32'h0000_007F,
		32'h0000_007F, 32'h0000_007F, 32'h0000_0000, 32'h0000_0000, 32'h0000_007F};
	logic                aclk, aresetn, hires_jumper, hold, jitter;
	logic [7:0]          s_awaddr, s_araddr;
	logic [31:0]         s_wdata, s_rdata;
	logic [3:0]          s_wstrb;
	logic [1:0]          s_bresp, s_rresp;
	logic                s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic                s_arvalid, s_arready, s_rvalid, s_rready;
	logic                hsync, vsync, blank, char_tick, pix_valid, pix_ready;
	crtg_pkg::crtg_pix_s pix_data, last_vis;
	int                  line_chars, line_clks, frame_lines, vis_chars, vs_chars, n_tick, n_xfer;
	int                  n_fail, check_count, ht, rlr, t, vtf;
	crtg_top #(.HI_DIV(HI), .LO_DIV(LO)) uut (.aclk, .aresetn, .hires_jumper, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .hsync, .vsync, .blank,
		.char_tick, .pix_data, .pix_valid, .pix_ready);
	crtg_monitor_model mon (.aclk, .aresetn, .hsync, .vsync, .blank, .char_tick, .pix_data, .pix_valid,
		.pix_ready, .hold, .jitter, .line_chars, .line_clks, .frame_lines, .vis_chars, .vs_chars,
		.n_tick, .n_xfer, .last_vis);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_awready === 1'b1) begin
				aw = 1'b0;
				s_awvalid <= 1'b0;
			end
			if (w && s_wready === 1'b1) begin
				w = 1'b0;
				s_wvalid <= 1'b0;
			end
		end
		while (s_bvalid !== 1'b1)
			@(posedge aclk);
		chk({30'h0, s_bresp}, {30'h0, er});
		s_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		while (s_rvalid !== 1'b1)
			@(posedge aclk);
		chk(s_rdata, ed);
		chk({30'h0, s_rresp}, {30'h0, er});
		s_rready <= 1'b0;
	endtask : axr
	task automatic wait_vs(input int n);
		repeat (n) @(posedge vsync);
		// Model latches its counts one edge after the rise
		repeat (2) @(posedge aclk);
	endtask : wait_vs
	function automatic int lines_of(input int vtc, input int vtf, input int rl);
		return (vtc + 1) * (rl + 1) + vtf + 1;
	endfunction : lines_of
	initial begin
		#2_000_000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		{aresetn, hires_jumper, hold, jitter, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		s_wstrb = 4'hF;
		void'($urandom(32'hda97_0f4e));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			if (i != 7)
				axr(8'(4 * i), RV[i], crtg_pkg::RESP_OKAY);
		axw(8'h1C, $urandom, crtg_pkg::RESP_OKAY);
		axw(8'h24, $urandom, crtg_pkg::RESP_SLVERR);
		axr(8'h24, 32'h0000_0000, crtg_pkg::RESP_SLVERR);
		for (int i = 0; i < 9; i++)
			if (i < 6 || i == 8) begin
				t = $urandom;
				axw(8'(4 * i), t, crtg_pkg::RESP_OKAY);
				axr(8'(4 * i), t & MK[i], crtg_pkg::RESP_OKAY);
			end
		$display("register test done");
		for (int k = 0; k < 2; k++) begin
			ht = (k == 0) ? 19 : 16 + int'($urandom % 16);
			rlr = (k == 0) ? 1 : int'($urandom % 3);
			hires_jumper <= k[0] ? 1'b0 : 1'b1;
			t = 5 * (rlr + 1) + int'($urandom % (rlr + 1));
			vtf = t % (rlr + 1);
			axw(8'h00, 32'(ht), crtg_pkg::RESP_OKAY);
			axw(8'h04, 32'(t / (rlr + 1) - 1), crtg_pkg::RESP_OKAY);
			axw(8'h08, 32'(vtf), crtg_pkg::RESP_OKAY);
			axw(8'h0C, 32'h0000_0001, crtg_pkg::RESP_OKAY);
			axw(8'h10, 32'h0000_0002, crtg_pkg::RESP_OKAY);
			axw(8'h14, 32'(rlr), crtg_pkg::RESP_OKAY);
			while (blank !== 1'b1)
				@(posedge aclk);
			axw(8'h20, 32'h0000_0015, crtg_pkg::RESP_OKAY);
			axw(8'h18, 32'h0000_0401, crtg_pkg::RESP_OKAY);
			jitter <= 1'b1;
			wait_vs(3);
			chk(line_chars, ht + 1);
			chk(frame_lines, lines_of(4, vtf, rlr));
			chk({25'h0, last_vis.col}, 32'(ht));
			chk({27'h0, last_vis.row}, 32'h0000_0000);
			chk({31'h0, last_vis.flash_on}, 32'h0000_0001);
			chk(vis_chars, (rlr + 1) * (ht + 1));
			chk(vs_chars, 3 * (rlr + 1) * (ht + 1));
			chk({29'h0, last_vis.fg}, 32'h0000_0005);
			chk({29'h0, last_vis.bg}, 32'h0000_0002);
			jitter <= 1'b0;
			wait_vs(2);
			chk(line_clks, (ht + 1) * (k[0] ? LO : HI));
			$display("timing test %0d done", k);
		end
		hold <= 1'b1;
		repeat (30) @(posedge aclk);
		t = n_tick;
		repeat (10) @(posedge aclk);
		chk(n_tick, t);
		chk(n_tick - n_xfer, 2);
		chk({31'h0, pix_valid}, 32'h0000_0001);
		hold <= 1'b0;
		repeat (20) @(posedge aclk);
		chk({31'h0, n_tick > t}, 32'h0000_0001);
		$display("buffer test done");
		report_and_stop();
	end
endmodule : tb_crtg_top
`default_nettype wire
